// [design/ccr_regs.svh]
// offsets, field positions, reset values and timing for the channel setup registers
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH
`define CCR_CLK_HZ        100000000
`define CCR_STRIDE        12
`define CCR_OFS_FUNC      8'h01
`define CCR_OFS_ADC       8'h02
`define CCR_OFS_DIN0      8'h03
`define CCR_OFS_DIN1      8'h04
`define CCR_OFS_OUT       8'h05
`define CCR_OFS_RTD       8'h06
`define CCR_OFS_DAC       8'h0A
`define CCR_OFS_CMD       8'h74
`define CCR_RST_ADC       16'h0100
`define CCR_RST_DIN0      16'h000B
`define CCR_RST_DIN1      16'h0049
`define CCR_RST_OUT       16'h0100
`define CCR_RST_RTD       16'h0001
`define CCR_WM_ADC        16'h0F77
`define CCR_WM_DIN0       16'hFFDF
`define CCR_WM_DIN1       16'h07FF
`define CCR_WM_OUT        16'hDEFF
`define CCR_WM_RTD        16'h000F
`define CCR_B_COUNT_EN    15
`define CCR_B_INVERT      14
`define CCR_B_COMP_EN     13
`define CCR_B_DB_MODE     6
`define CCR_B_ALM_PERIOD  12
`define CCR_B_DEFER       10
`define CCR_B_DRV_DLY     9
`define CCR_B_SETTLED     8
`define CCR_B_RTD_REF     3
`define CCR_DB_TIME_US    240
`define CCR_DB_TIME_CODE  11
`define CCR_DB_TICK_CYC   ((`CCR_DB_TIME_US * (`CCR_CLK_HZ / 1000000) + `CCR_DB_TIME_CODE - 1) / `CCR_DB_TIME_CODE)
`define CCR_ALM_SHORT_MS  4
`define CCR_ALM_LONG_MS   20
`define CCR_DRV_LONG_MS   4
`define CCR_DRV_SHORT_US  200
`define CCR_ALM_SHORT_CYC (`CCR_ALM_SHORT_MS * (`CCR_CLK_HZ / 1000))
`define CCR_ALM_LONG_CYC  (`CCR_ALM_LONG_MS * (`CCR_CLK_HZ / 1000))
`define CCR_DRV_LONG_CYC  (`CCR_DRV_LONG_MS * (`CCR_CLK_HZ / 1000))
`define CCR_DRV_SHORT_CYC (`CCR_DRV_SHORT_US * (`CCR_CLK_HZ / 1000000))
`define CCR_RATE0_HZ      4800
`define CCR_RATE1_HZ      76800
`define CCR_RATE2_HZ      153600
`define CCR_RATE3_HZ      230400
`define CCR_RATE0_CYC     (`CCR_CLK_HZ / `CCR_RATE0_HZ)
`define CCR_RATE1_CYC     (`CCR_CLK_HZ / `CCR_RATE1_HZ)
`define CCR_RATE2_CYC     (`CCR_CLK_HZ / `CCR_RATE2_HZ)
`define CCR_RATE3_CYC     (`CCR_CLK_HZ / `CCR_RATE3_HZ)
`define CCR_STEP0         16'h020C
`define CCR_STEP1         16'h03D7
`define CCR_STEP2         16'h0F9E
`define CCR_STEP3         16'h38D5
`endif

// [design/ccr_pkg.sv]
// types shared by the channel setup registers
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_SLEW_OFF    = 2'h0,
    CCR_SLEW_LINEAR = 2'h1,
    CCR_SLEW_MODEM  = 2'h2,
    CCR_SLEW_RSVD   = 2'h3
  } ccr_slew_t;
  typedef enum logic [3:0] {
    CCR_FN_HIGH_IMPEDANCE_FUNCTION = 4'h0,
    CCR_FN_VOLTAGE_OUT             = 4'h1,
    CCR_FN_CURRENT_OUTPUT_FUNCTION = 4'h2,
    CCR_FN_VOLTAGE_IN              = 4'h3,
    CCR_FN_CURRENT_IN_EXT          = 4'h4,
    CCR_FN_CURRENT_IN_LOOP         = 4'h5,
    CCR_FN_RESISTANCE              = 4'h7,
    CCR_FN_DIGITAL_IN              = 4'h8,
    CCR_FN_DIGITAL_IN_LOOP         = 4'h9,
    CCR_FN_MODEM_CURRENT_OUTPUT    = 4'hA,
    CCR_FN_CURRENT_IN_EXT_MODEM    = 4'hB,
    CCR_FN_CURRENT_IN_LOOP_MODEM   = 4'hC
  } ccr_func_t;
endpackage

// [design/ccr_channel_config.sv]
// per-channel setup registers with debounce, counting, alarm, driver delay and slew logic
`include "ccr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ccr_channel_config #(
  parameter int unsigned N_CH          = 4,
  parameter int unsigned ALM_SHORT_CYC = `CCR_ALM_SHORT_CYC,
  parameter int unsigned ALM_LONG_CYC  = `CCR_ALM_LONG_CYC,
  parameter int unsigned DRV_LONG_CYC  = `CCR_DRV_LONG_CYC,
  parameter int unsigned DRV_SHORT_CYC = `CCR_DRV_SHORT_CYC,
  parameter int unsigned RATE0_CYC     = `CCR_RATE0_CYC,
  parameter logic [15:0] DAC_KEY       = 16'h00A5,  // arbitrary update key
  parameter logic [15:0] DAC_OFS_CODE  = 16'h0100   // arbitrary offset code
) (
  input  wire logic              CLK,
  input  wire logic              RST_B,
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic [15:0]       REG_WDATA,
  input  wire logic              REG_WE,
  input  wire logic              REG_RE,
  output logic      [15:0]       REG_RDATA,
  input  wire logic [N_CH-1:0]   DIN_COMP,
  input  wire logic [2*N_CH-1:0] ALARM_RAW,
  input  wire logic [N_CH-1:0]   BIAS_READY,
  input  wire logic [N_CH-1:0]   SUPPLY_TRACK_LO,
  input  wire logic [N_CH-1:0]   RTD_CONV,
  input  wire logic [16*N_CH-1:0] CAL_OFFSET,
  output logic      [16*N_CH-1:0] CFG_ADC,
  output logic      [16*N_CH-1:0] CFG_DIN0,
  output logic      [16*N_CH-1:0] CFG_DIN1,
  output logic      [16*N_CH-1:0] CFG_OUT,
  output logic      [16*N_CH-1:0] CFG_RTD,
  output logic      [N_CH-1:0]   DIN_LEVEL,
  output logic      [32*N_CH-1:0] DIN_COUNT,
  output logic      [2*N_CH-1:0] ALARM_OUT,
  output logic      [N_CH-1:0]   DRV_EN,
  output logic      [N_CH-1:0]   SUPPLY_LO,
  output logic      [16*N_CH-1:0] DAC_ACTIVE,
  output logic      [16*N_CH-1:0] RTD_OFFSET
);
  localparam int CW = $clog2(ALM_LONG_CYC + DRV_LONG_CYC + 1);
  localparam int SW = $clog2(RATE0_CYC + 1);

  // register images visible to the read mux
  logic [15:0] adc_q  [N_CH];
  logic [15:0] din0_q [N_CH];
  logic [15:0] din1_q [N_CH];
  logic [15:0] out_q  [N_CH];
  logic [15:0] rtd_q  [N_CH];
  logic        settled_q [N_CH];
  logic [11:0] db_div, next_db_div;
  logic [SW-1:0] mdm_div, next_mdm_div;
  logic        db_tick, mdm_tick;
  logic [15:0] next_rdata;

  // unlisted codes fall back to high impedance
  function automatic ccr_pkg::ccr_func_t decode_func(input logic [3:0] code);
    if (code inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC}) begin
      decode_func = ccr_pkg::ccr_func_t'(code);
    end else begin
      decode_func = ccr_pkg::CCR_FN_HIGH_IMPEDANCE_FUNCTION;
    end
  endfunction

  // span and node loaded on every function write
  function automatic logic [5:0] func_defaults(input ccr_pkg::ccr_func_t f);
    case (f)
      ccr_pkg::CCR_FN_CURRENT_OUTPUT_FUNCTION,
      ccr_pkg::CCR_FN_MODEM_CURRENT_OUTPUT: func_defaults = {3'h0, 3'h1};
      ccr_pkg::CCR_FN_RESISTANCE:           func_defaults = {3'h5, 3'h3};
      ccr_pkg::CCR_FN_VOLTAGE_OUT:          func_defaults = {3'h1, 3'h0};
      default:                              func_defaults = {3'h0, 3'h0};
    endcase
  endfunction

  // one step of a slewer, never overshooting the goal
  function automatic logic [15:0] step_toward(input logic [15:0] cur, input logic [15:0] goal,
                                              input logic [15:0] step);
    logic [16:0] sum;
    sum = {1'b0, cur} + {1'b0, step};
    if (cur < goal) begin
      step_toward = (sum >= {1'b0, goal}) ? goal : sum[15:0];
    end else if (cur > goal) begin
      step_toward = (cur - goal <= step) ? goal : cur - step;
    end else begin
      step_toward = cur;
    end
  endfunction

  // shared dividers and the registered read port
  always_comb begin
    db_tick = (db_div == 12'(`CCR_DB_TICK_CYC - 1));
    mdm_tick = (mdm_div == SW'(RATE0_CYC - 1));
    next_db_div = db_tick ? 12'h000 : db_div + 12'h001;
    next_mdm_div = mdm_tick ? '0 : mdm_div + SW'(1);
    next_rdata = REG_RDATA;
    if (REG_RE) begin
      next_rdata = 16'h0000;  // unmapped addresses answer zero
      for (int c = 0; c < N_CH; c++) begin
        if (REG_ADDR == `CCR_OFS_ADC + 8'(c * `CCR_STRIDE)) next_rdata = adc_q[c];
        if (REG_ADDR == `CCR_OFS_DIN0 + 8'(c * `CCR_STRIDE)) next_rdata = din0_q[c];
        if (REG_ADDR == `CCR_OFS_DIN1 + 8'(c * `CCR_STRIDE)) next_rdata = din1_q[c];
        if (REG_ADDR == `CCR_OFS_OUT + 8'(c * `CCR_STRIDE)) begin
          next_rdata = out_q[c] | (16'(settled_q[c]) << `CCR_B_SETTLED);
        end
        if (REG_ADDR == `CCR_OFS_RTD + 8'(c * `CCR_STRIDE)) next_rdata = rtd_q[c];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      db_div <= 12'h000;
      mdm_div <= '0;
      REG_RDATA <= 16'h0000;
    end else begin
      db_div <= next_db_div;
      mdm_div <= next_mdm_div;
      REG_RDATA <= next_rdata;
    end
  end

  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    localparam logic [7:0] CB = 8'(c * `CCR_STRIDE);
    logic wr_func, wr_adc, wr_din0, wr_din1, wr_out, wr_rtd, wr_dac, wr_key;
    ccr_pkg::ccr_func_t fn, nf;
    ccr_pkg::ccr_slew_t slew;
    logic [3:0]  func_q, next_func;
    logic [15:0] next_adc, next_din0, next_din1, next_out, next_rtd;
    logic        din_s1, din_s2, bias_s1, bias_s2, trk_s1, trk_s2;
    logic [1:0]  alm_s1, alm_s2, alm_q, next_alm;
    logic [CW-1:0] alm_cnt [2];
    logic [CW-1:0] next_alm_cnt [2];
    logic [CW-1:0] alm_per, drv_dly, drv_cnt, next_drv_cnt;
    logic        din_i, lvl, next_lvl, drv, next_drv, sup, next_sup, next_settled;
    logic [4:0]  dcnt, next_dcnt;
    logic [31:0] cnt, next_cnt;
    logic [15:0] code, next_code, tgt, next_tgt, act, next_act, mpos, next_mpos;
    logic [15:0] step, rofs, next_rofs;
    logic [SW-1:0] ltick, next_ltick, lper;

    assign wr_func = REG_WE && REG_ADDR == `CCR_OFS_FUNC + CB;
    assign wr_adc  = REG_WE && REG_ADDR == `CCR_OFS_ADC + CB;
    assign wr_din0 = REG_WE && REG_ADDR == `CCR_OFS_DIN0 + CB;
    assign wr_din1 = REG_WE && REG_ADDR == `CCR_OFS_DIN1 + CB;
    assign wr_out  = REG_WE && REG_ADDR == `CCR_OFS_OUT + CB;
    assign wr_rtd  = REG_WE && REG_ADDR == `CCR_OFS_RTD + CB;
    assign wr_dac  = REG_WE && REG_ADDR == `CCR_OFS_DAC + CB;
    assign wr_key  = REG_WE && REG_ADDR == `CCR_OFS_CMD && REG_WDATA == DAC_KEY;

    // every next value of the channel
    always_comb begin
      fn = decode_func(func_q);
      nf = decode_func(REG_WDATA[3:0]);
      slew = ccr_pkg::ccr_slew_t'(out_q[c][6:5]);
      next_func = func_q;
      // writable fields only; reserved bits stay zero
      next_adc  = wr_adc ? REG_WDATA & `CCR_WM_ADC : adc_q[c];
      next_din0 = wr_din0 ? REG_WDATA & `CCR_WM_DIN0 : din0_q[c];
      next_din1 = wr_din1 ? REG_WDATA & `CCR_WM_DIN1 : din1_q[c];
      next_out  = wr_out ? REG_WDATA & `CCR_WM_OUT : out_q[c];
      next_rtd  = wr_rtd ? REG_WDATA & `CCR_WM_RTD : rtd_q[c];
      next_code = wr_dac ? REG_WDATA : code;
      next_tgt = tgt;
      next_mpos = mpos;
      if (wr_dac && !out_q[c][`CCR_B_DEFER]) next_tgt = REG_WDATA;
      if (wr_key) next_tgt = code;
      // function write overrides a same-cycle field write
      if (wr_func) begin
        next_func = REG_WDATA[3:0];
        {next_adc[6:4], next_adc[2:0]} = func_defaults(nf);
        next_din0[`CCR_B_COMP_EN] = nf inside {ccr_pkg::CCR_FN_DIGITAL_IN, ccr_pkg::CCR_FN_DIGITAL_IN_LOOP};
        next_din0[11:7] = 5'h00;
        if (fn == ccr_pkg::CCR_FN_HIGH_IMPEDANCE_FUNCTION && nf != ccr_pkg::CCR_FN_HIGH_IMPEDANCE_FUNCTION) begin
          next_mpos = DAC_OFS_CODE;
        end
      end
      // debounce on the comparator, inverted when the invert bit is set
      din_i = din_s2 ^ din0_q[c][`CCR_B_INVERT];
      next_dcnt = dcnt;
      next_lvl = lvl;
      if (din0_q[c][4:0] == 5'h00) begin
        next_dcnt = 5'h00;
        next_lvl = din_i;
      end else if (db_tick) begin
        if (din_i) begin
          next_dcnt = (dcnt < din0_q[c][4:0]) ? dcnt + 5'h01 : dcnt;
        end else if (!din0_q[c][`CCR_B_DB_MODE]) begin
          next_dcnt = (dcnt != 5'h00) ? dcnt - 5'h01 : dcnt;
        end else begin
          next_dcnt = 5'h00;
        end
        if (next_dcnt >= din0_q[c][4:0]) next_lvl = 1'b1;
        else if (next_dcnt == 5'h00) next_lvl = 1'b0;
      end
      // rising edges normally, falling edges when inverted
      next_cnt = cnt;
      if (din0_q[c][`CCR_B_COUNT_EN] && lvl != next_lvl && next_lvl != din0_q[c][`CCR_B_INVERT]) begin
        next_cnt = cnt + 32'h0000_0001;
      end
      // alarm deglitch only in voltage output
      alm_per = out_q[c][`CCR_B_ALM_PERIOD] ? CW'(ALM_LONG_CYC) : CW'(ALM_SHORT_CYC);
      next_alm = alm_q;
      for (int k = 0; k < 2; k++) begin
        next_alm_cnt[k] = '0;
        if (fn != ccr_pkg::CCR_FN_VOLTAGE_OUT) begin
          next_alm[k] = alm_s2[k];
        end else if (alm_s2[k] != alm_q[k]) begin
          if (alm_cnt[k] >= alm_per - CW'(1)) next_alm[k] = alm_s2[k];
          else next_alm_cnt[k] = alm_cnt[k] + CW'(1);
        end
      end
      // bias-to-drive delay, programmable only for modem output
      drv_dly = (fn == ccr_pkg::CCR_FN_MODEM_CURRENT_OUTPUT && !out_q[c][`CCR_B_DRV_DLY]) ?
                CW'(DRV_LONG_CYC) : CW'(DRV_SHORT_CYC);
      next_drv_cnt = '0;
      next_drv = 1'b0;
      if (bias_s2) begin
        next_drv = drv || (drv_cnt >= drv_dly - CW'(1));
        next_drv_cnt = next_drv ? drv_cnt : drv_cnt + CW'(1);
      end
      // supply lock or tracking
      unique case (out_q[c][15:14])
        2'h0: next_sup = 1'b0;
        2'h1: next_sup = 1'b1;
        2'h2: next_sup = trk_s2 && fn inside {ccr_pkg::CCR_FN_CURRENT_OUTPUT_FUNCTION,
                                              ccr_pkg::CCR_FN_MODEM_CURRENT_OUTPUT};
        2'h3: next_sup = 1'b0;
      endcase
      // linear step and update rate
      unique case (out_q[c][4:3])
        2'h0: step = `CCR_STEP0;
        2'h1: step = `CCR_STEP1;
        2'h2: step = `CCR_STEP2;
        2'h3: step = `CCR_STEP3;
      endcase
      unique case (out_q[c][2:1])
        2'h0: lper = SW'(RATE0_CYC);
        2'h1: lper = SW'(`CCR_RATE1_CYC);
        2'h2: lper = SW'(`CCR_RATE2_CYC);
        2'h3: lper = SW'(`CCR_RATE3_CYC);
      endcase
      next_ltick = (ltick >= lper - SW'(1)) ? '0 : ltick + SW'(1);
      // modem slewer runs all the time at the slow rate
      if (mdm_tick && !(wr_func && next_mpos != mpos)) next_mpos = step_toward(mpos, tgt, `CCR_STEP0);
      next_settled = (next_mpos == next_tgt);
      next_act = act;
      unique case (slew)
        ccr_pkg::CCR_SLEW_OFF:    next_act = act;
        ccr_pkg::CCR_SLEW_LINEAR: if (next_ltick == '0) next_act = step_toward(act, tgt, step);
        ccr_pkg::CCR_SLEW_MODEM:  next_act = mpos;
        ccr_pkg::CCR_SLEW_RSVD:   next_act = act;
      endcase
      // offset scaling during a resistance conversion
      next_rofs = 16'h0000;
      if (RTD_CONV[c] && fn == ccr_pkg::CCR_FN_RESISTANCE) begin
        next_rofs = rtd_q[c][`CCR_B_RTD_REF] ? {CAL_OFFSET[16*c+:15], 1'b0} : CAL_OFFSET[16*c+:16];
      end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        func_q <= 4'h0;
        adc_q[c] <= `CCR_RST_ADC;
        din0_q[c] <= `CCR_RST_DIN0;
        din1_q[c] <= `CCR_RST_DIN1;
        out_q[c] <= `CCR_RST_OUT & `CCR_WM_OUT;
        rtd_q[c] <= `CCR_RST_RTD;
        settled_q[c] <= 1'b1;
        {din_s1, din_s2, bias_s1, bias_s2, trk_s1, trk_s2} <= 6'h00;
        {alm_s1, alm_s2, alm_q} <= 6'h00;
        alm_cnt[0] <= '0;
        alm_cnt[1] <= '0;
        dcnt <= 5'h00;
        lvl <= 1'b0;
        cnt <= 32'h0000_0000;
        {code, tgt, act, mpos, rofs} <= 80'h0;
        drv_cnt <= '0;
        drv <= 1'b0;
        sup <= 1'b0;
        ltick <= '0;
      end else begin
        func_q <= next_func;
        adc_q[c] <= next_adc;
        din0_q[c] <= next_din0;
        din1_q[c] <= next_din1;
        out_q[c] <= next_out;
        rtd_q[c] <= next_rtd;
        settled_q[c] <= next_settled;
        // two-stage synchronisers on pin inputs
        {din_s1, din_s2} <= {DIN_COMP[c], din_s1};
        {bias_s1, bias_s2} <= {BIAS_READY[c], bias_s1};
        {trk_s1, trk_s2} <= {SUPPLY_TRACK_LO[c], trk_s1};
        alm_s1 <= ALARM_RAW[2*c+:2];
        alm_s2 <= alm_s1;
        alm_q <= next_alm;
        alm_cnt[0] <= next_alm_cnt[0];
        alm_cnt[1] <= next_alm_cnt[1];
        dcnt <= next_dcnt;
        lvl <= next_lvl;
        cnt <= next_cnt;
        {code, tgt, act, mpos, rofs} <= {next_code, next_tgt, next_act, next_mpos, next_rofs};
        drv_cnt <= next_drv_cnt;
        drv <= next_drv;
        sup <= next_sup;
        ltick <= next_ltick;
      end
    end

    // register images and channel state onto the ports
    assign CFG_ADC[16*c+:16] = adc_q[c];
    assign CFG_DIN0[16*c+:16] = din0_q[c];
    assign CFG_DIN1[16*c+:16] = din1_q[c];
    assign CFG_OUT[16*c+:16] = out_q[c] | (16'(settled_q[c]) << `CCR_B_SETTLED);
    assign CFG_RTD[16*c+:16] = rtd_q[c];
    assign DIN_LEVEL[c] = lvl;
    assign DIN_COUNT[32*c+:32] = cnt;
    assign ALARM_OUT[2*c+:2] = alm_q;
    assign DRV_EN[c] = drv;
    assign SUPPLY_LO[c] = sup;
    assign DAC_ACTIVE[16*c+:16] = act;
    assign RTD_OFFSET[16*c+:16] = rofs;
  end
endmodule
`default_nettype wire

// [sim/ccr_channel_config_props.sv]
// assertion checker for the channel setup registers, channel 0
`timescale 1ns/1ps
`default_nettype none
module ccr_channel_config_props #(
  parameter int unsigned N_CH = 4
) (
  input wire logic               CLK,
  input wire logic               RST_B,
  input wire logic [7:0]         REG_ADDR,
  input wire logic [15:0]        REG_WDATA,
  input wire logic               REG_WE,
  input wire logic [N_CH-1:0]    DIN_COMP,
  input wire logic [N_CH-1:0]    BIAS_READY,
  input wire logic [N_CH-1:0]    RTD_CONV,
  input wire logic [16*N_CH-1:0] CAL_OFFSET,
  input wire logic [16*N_CH-1:0] CFG_ADC,
  input wire logic [16*N_CH-1:0] CFG_DIN0,
  input wire logic [16*N_CH-1:0] CFG_DIN1,
  input wire logic [16*N_CH-1:0] CFG_OUT,
  input wire logic [16*N_CH-1:0] CFG_RTD,
  input wire logic [N_CH-1:0]    DIN_LEVEL,
  input wire logic [32*N_CH-1:0] DIN_COUNT,
  input wire logic [N_CH-1:0]    DRV_EN,
  input wire logic [N_CH-1:0]    SUPPLY_LO,
  input wire logic [16*N_CH-1:0] RTD_OFFSET
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // function write to channel 0
  logic fn0;
  assign fn0 = REG_WE && REG_ADDR == 8'h01;
  a_sink_clear: assert property (fn0 |=> CFG_DIN0[11:7] == 5'h00)
    else $error("sink code survived a function write");
  a_comp_default: assert property (fn0 |=> CFG_DIN0[13] == ($past(REG_WDATA[3:0]) inside {4'h8, 4'h9}))
    else $error("comparator enable default wrong");
  a_span_resist: assert property (fn0 && REG_WDATA[3:0] == 4'h7 |=> CFG_ADC[6:0] == 7'h53)
    else $error("resistance span and node defaults wrong");
  a_unlisted_hiz: assert property (fn0 && REG_WDATA[3:0] > 4'hC |=> CFG_ADC[6:0] == 7'h00 && !CFG_DIN0[13])
    else $error("unlisted function not treated as high impedance");
  a_thresh_mask: assert property (REG_WE && REG_ADDR == 8'h04 |=> CFG_DIN1[15:0] == ($past(REG_WDATA) & 16'h07FF))
    else $error("threshold register write mask wrong");
  a_supply_lock: assert property (CFG_OUT[15:14] == 2'h1 [*2] |-> SUPPLY_LO[0])
    else $error("low supply lock not applied");
  // in bypass the level follows the synced comparator, inverted when the invert bit is set
  a_bypass_level: assert property ((CFG_DIN0[4:0] == 5'h00 && $stable(DIN_COMP[0]) && $stable(CFG_DIN0[14])) [*5]
    |-> DIN_LEVEL[0] == (DIN_COMP[0] ^ CFG_DIN0[14]))
    else $error("bypassed debounce level wrong");
  a_count_step: assert property ($changed(DIN_COUNT[31:0]) |-> DIN_COUNT[31:0] == $past(DIN_COUNT[31:0]) + 32'h1)
    else $error("edge counter moved by more than one");
  a_drv_drop: assert property (!BIAS_READY[0] [*4] |-> !DRV_EN[0])
    else $error("driver enabled without bias");
  a_rtd_idle: assert property (!RTD_CONV[0] |=> RTD_OFFSET[15:0] == 16'h0000)
    else $error("offset present outside conversion");
  a_rtd_scale: assert property (RTD_OFFSET[15:0] != 16'h0000 |-> $past(RTD_CONV[0]) &&
    RTD_OFFSET[15:0] == ($past(CFG_RTD[3]) ? {$past(CAL_OFFSET[14:0]), 1'b0} : $past(CAL_OFFSET[15:0])))
    else $error("offset scaling without conversion");
  c_count: cover property ($changed(DIN_COUNT[31:0]));
  c_drive: cover property ($rose(DRV_EN[0]));
  c_offset: cover property (RTD_OFFSET[15:0] != 16'h0000);
endmodule
bind ccr_channel_config ccr_channel_config_props #(.N_CH(N_CH)) u_props (
  .CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE),
  .DIN_COMP(DIN_COMP), .BIAS_READY(BIAS_READY), .RTD_CONV(RTD_CONV), .CAL_OFFSET(CAL_OFFSET),
  .CFG_ADC(CFG_ADC), .CFG_DIN0(CFG_DIN0), .CFG_DIN1(CFG_DIN1), .CFG_OUT(CFG_OUT), .CFG_RTD(CFG_RTD),
  .DIN_LEVEL(DIN_LEVEL),
  .DIN_COUNT(DIN_COUNT), .DRV_EN(DRV_EN), .SUPPLY_LO(SUPPLY_LO), .RTD_OFFSET(RTD_OFFSET));
`default_nettype wire

// [sim/testbench.sv]
// self-checking testbench for the channel setup registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic [7:0]   reg_addr = 8'h00;
  logic [15:0]  reg_wdata = 16'h0000;
  logic         reg_we = 1'b0;
  logic         reg_re = 1'b0;
  logic [15:0]  reg_rdata;
  logic [3:0]   din_comp = 4'h0;
  logic [3:0]   bias_ready = 4'h0;
  logic [3:0]   track_lo = 4'h0;
  logic [3:0]   rtd_conv = 4'h0;
  logic [63:0]  cal_offset = 64'h0;
  logic [7:0]   alarm_raw = 8'h00;
  logic [7:0]   alarm_out;
  logic [63:0]  cfg_adc, cfg_din0, cfg_din1, cfg_out, cfg_rtd, dac_active, rtd_offset;
  logic [3:0]   din_level, drv_en, supply_lo;
  logic [127:0] din_count;
  int           errors = 0;
  int           samples_checked = 0;
  // shortened timing constants keep the run short
  ccr_channel_config #(.ALM_SHORT_CYC(40), .ALM_LONG_CYC(200), .DRV_LONG_CYC(40), .DRV_SHORT_CYC(8),
    .RATE0_CYC(20)) dut (.CLK(clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata), .DIN_COMP(din_comp), .ALARM_RAW(alarm_raw),
    .BIAS_READY(bias_ready), .SUPPLY_TRACK_LO(track_lo), .RTD_CONV(rtd_conv), .CAL_OFFSET(cal_offset),
    .CFG_ADC(cfg_adc), .CFG_DIN0(cfg_din0), .CFG_DIN1(cfg_din1), .CFG_OUT(cfg_out), .CFG_RTD(cfg_rtd),
    .DIN_LEVEL(din_level), .DIN_COUNT(din_count), .ALARM_OUT(alarm_out), .DRV_EN(drv_en), .SUPPLY_LO(supply_lo),
    .DAC_ACTIVE(dac_active), .RTD_OFFSET(rtd_offset));
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask
  // inputs change on the falling edge, the design takes them on the rising one
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clk);
    reg_we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge clk);
    reg_re = 1'b0;
    check($sformatf("register %h", a), {16'h0, exp}, {16'h0, reg_rdata & m});
  endtask
  // bounded wait: 0 level, 1 driver enable, 2 settled flag
  task automatic wait_for(input int sel, input logic v, output int n);
    n = 0;
    while ((sel == 0 ? din_level[0] : sel == 1 ? drv_en[0] : cfg_out[8]) !== v) begin
      n++;
      if (n > 5000) begin
        check("bounded wait", 1, 0);
        complete_run();
      end
      @(negedge clk);
    end
  endtask
  task automatic t_reset;
    logic [7:0] b;
    for (int c = 0; c < 4; c++) begin
      b = 8'(12 * c);
      rd(b + 8'h01, 16'hFFFF, 16'h0000);
      rd(b + 8'h02, 16'hFFFF, 16'h0100);
      rd(b + 8'h03, 16'hFFFF, 16'h000B);
      rd(b + 8'h04, 16'hFFFF, 16'h0049);
      rd(b + 8'h05, 16'hFFFF, 16'h0100);
      rd(b + 8'h06, 16'hFFFF, 16'h0001);
    end
  endtask
  // all-ones writes show which bits stick; ADC low byte written as 74, threshold kept at the 98 ceiling
  task automatic t_masks;
    wr(8'h02, 16'hFF74);
    rd(8'h02, 16'hFFFF, 16'h0F74);
    wr(8'h03, 16'hFFFF);
    rd(8'h03, 16'hFFFF, 16'hFFDF);
    wr(8'h04, 16'hFFE2);
    rd(8'h04, 16'hFFFF, 16'h07E2);
    wr(8'h05, 16'hFFFF);
    rd(8'h05, 16'hFEFF, 16'hDEFF);
    wr(8'h05, 16'h0000);
    wr(8'h06, 16'hFFFF);
    rd(8'h06, 16'hFFFF, 16'h000F);
  endtask
  task automatic t_func;
    logic [3:0] fn [8] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'h8, 4'h9, 4'hA, 4'hD};
    logic [7:0] adc [8] = '{8'h00, 8'h10, 8'h01, 8'h53, 8'h00, 8'h00, 8'h01, 8'h00};
    for (int i = 0; i < 8; i++) begin
      wr(8'h01, 16'h0000);
      wr(8'h02, 16'h0F77);
      wr(8'h03, 16'h4F8B);
      wr(8'h01, {12'h000, fn[i]});
      rd(8'h02, 16'hFFFF, {8'h0F, adc[i]});
      rd(8'h03, 16'hFFFF, fn[i] inside {4'h8, 4'h9} ? 16'h600B : 16'h400B);
    end
    wr(8'h01, 16'h0000);
  endtask
  task automatic t_count;
    logic [31:0] c0;
    int          n;
    wr(8'h03, 16'h8000);
    cycles(8);
    c0 = din_count[31:0];
    for (int i = 0; i < 3; i++) begin
      din_comp[0] = 1'b1;
      cycles(8);
      check("bypass level", 1, din_level[0]);
      din_comp[0] = 1'b0;
      cycles(8);
    end
    check("rising count", c0 + 3, din_count[31:0]);
    wr(8'h03, 16'hC000);
    cycles(8);
    check("inverted level", 1, din_level[0]);
    c0 = din_count[31:0];
    din_comp[0] = 1'b1;
    cycles(8);
    check("falling counted", c0 + 1, din_count[31:0]);
    din_comp[0] = 1'b0;
    cycles(8);
    check("rising ignored", c0 + 1, din_count[31:0]);
    // one low tick at code 2: the integrator holds, mode 1 clears
    for (int m = 0; m < 2; m++) begin
      din_comp[0] = 1'b0;
      wr(8'h03, m ? 16'h0042 : 16'h0002);
      wait_for(0, 1'b0, n);
      din_comp[0] = 1'b1;
      wait_for(0, 1'b1, n);
      din_comp[0] = 1'b0;
      cycles(2200);
      check("debounce drop", m ? 0 : 1, din_level[0]);
    end
  endtask
  task automatic t_rtd;
    cal_offset[15:0] = 16'h1234;
    wr(8'h01, 16'h0007);
    wr(8'h06, 16'h0001);
    rtd_conv[0] = 1'b1;
    cycles(3);
    check("offset 2 V", 16'h1234, rtd_offset[15:0]);
    rtd_conv[0] = 1'b0;
    wr(8'h06, 16'h0009);
    rtd_conv[0] = 1'b1;
    cycles(3);
    check("offset 1 V", 16'h2468, rtd_offset[15:0]);
    rtd_conv[0] = 1'b0;
    cycles(3);
    check("offset idle", 0, rtd_offset[15:0]);
    wr(8'h01, 16'h0000);
  endtask
  // deglitch only in voltage output, pass-through elsewhere
  task automatic t_alarm;
    wr(8'h01, 16'h0000);
    wr(8'h01, 16'h0001);
    alarm_raw[0] = 1'b1;
    cycles(20);
    check("short alarm early", 0, alarm_out[0]);
    cycles(30);
    check("short alarm", 1, alarm_out[0]);
    wr(8'h05, 16'h1000);
    alarm_raw[1] = 1'b1;
    cycles(100);
    check("open alarm early", 0, alarm_out[1]);
    cycles(150);
    check("open alarm", 1, alarm_out[1]);
    wr(8'h01, 16'h0000);
    alarm_raw = 8'h00;
    cycles(4);
    check("alarm pass", 0, alarm_out[1:0]);
  endtask
  // packed as {supply code nibble, function, track, expected}
  task automatic t_supply;
    logic [15:0] t [7] = '{16'h0210, 16'h4211, 16'h8211, 16'h8200, 16'h8810, 16'hC210, 16'h8A11};
    for (int i = 0; i < 7; i++) begin
      wr(8'h01, 16'h0000);
      wr(8'h01, {12'h000, t[i][11:8]});
      wr(8'h05, {t[i][15:12], 12'h000});
      track_lo[0] = t[i][4];
      cycles(6);
      check("supply select", t[i][0], supply_lo[0]);
    end
  endtask
  task automatic t_drv;
    logic [3:0]  fn [3] = '{4'hA, 4'hA, 4'h2};
    logic [15:0] oc [3] = '{16'h0000, 16'h0200, 16'h0000};
    int          lo [3] = '{40, 8, 8};
    int          n;
    for (int i = 0; i < 3; i++) begin
      wr(8'h01, 16'h0000);
      wr(8'h01, {12'h000, fn[i]});
      wr(8'h05, oc[i]);
      bias_ready[0] = 1'b1;
      wait_for(1, 1'b1, n);
      check("driver delay", 1, n >= lo[i] && n <= lo[i] + 5);
      bias_ready[0] = 1'b0;
      cycles(5);
      check("driver off", 0, drv_en[0]);
    end
  endtask
  task automatic t_dac;
    int n;
    wr(8'h01, 16'h0000);
    wr(8'h01, 16'h0002);
    check("settled low", 0, cfg_out[8]);
    wr(8'h05, 16'h0438);
    wr(8'h0A, 16'h1000);
    cycles(60);
    check("held code", 0, dac_active[15:0]);
    wr(8'h74, 16'h00A5);
    cycles(60);
    check("loaded code", 16'h1000, dac_active[15:0]);
    wr(8'h05, 16'h0018);
    wr(8'h0A, 16'h8000);
    cycles(60);
    check("frozen code", 16'h1000, dac_active[15:0]);
    wr(8'h05, 16'h0038);
    for (int i = 0; i < 60 && dac_active[15:0] === 16'h1000; i++) @(negedge clk);
    check("linear step", 16'h48D5, dac_active[15:0]);
    wait_for(2, 1'b1, n);
    wr(8'h05, 16'h0040);
    cycles(3);
    check("modem slew", 16'h8000, dac_active[15:0]);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_masks();
    t_func();
    t_count();
    t_rtd();
    t_alarm();
    t_supply();
    t_drv();
    t_dac();
    complete_run();
  end
endmodule
`default_nettype wire
